// >>> verilog/nvlsa_pkg.sv
// Constants, commands and carriers for the NVM lock and section access block
package nvlsa_pkg;
    localparam int ADDR_W = 16;
    // Data-space decode
    localparam logic [3:0] SEC_CODE = 4'h4;
    localparam logic [9:0] SEG_LOCK = 10'h0FC;
    localparam logic [9:0] SEG_CFG = 10'h0FD;
    localparam logic [9:0] SEG_CAL = 10'h0FE;
    localparam logic [9:0] SEG_SIG = 10'h0FF;
    localparam int SEC_MSB = 15;
    localparam int SEC_LSB = 12;
    localparam int SEG_LSB = 6;
    // Section geometry
    localparam int CODE_WORDS = 2048;
    localparam int BYTE_SEL_BIT = 0;
    localparam int WORD_IN_PAGE_ADDR_LSB = 1;
    localparam int WORD_IN_PAGE_ADDR_MSB = 5;
    localparam int PADDR_LSB = 6;
    localparam int PADDR_MSB = 11;
    localparam int SIG_WORD_IN_PAGE_ADDR_MSB = 4;
    localparam int SIG_PAGE_BIT = 5;
    localparam logic [4:0] CFG_BYTE_WORD = 5'h00;
    localparam logic [5:0] LOCK_BYTE_OFS = 6'h00;
    // Reset and erased values
    localparam logic [7:0] LOCK_ERASED = 8'hFF;
    localparam logic [7:0] CFG_ERASED = 8'hFF;
    localparam logic [15:0] WORD_ERASED = 16'hFFFF;
    localparam logic [7:0] RSVD_BYTE = 8'hFF;
    // Field positions
    localparam int LB_TWO_BIT = 1;
    localparam int LB_ONE_BIT = 0;
    localparam int CFG_RST_DIS_BIT = 0;
    localparam int CFG_WDT_BIT = 1;
    localparam int CFG_SYSCLK_PIN_OUTPUT_BIT = 2;
    localparam int CFG_BOD_LSB = 4;
    localparam int CFG_BOD_MSB = 6;
    localparam logic [1:0] LOCK_NONE = 2'h3;
    localparam logic [1:0] LOCK_MODE2 = 2'h2;

    typedef enum logic [2:0] {
        CMD_NOP = 3'b000,
        CMD_CHIP_ERASE = 3'b001,
        CMD_SECT_ERASE = 3'b010,
        CMD_CFG_ERASE = 3'b011,
        CMD_CODE_WRITE = 3'b100,
        CMD_CFG_WRITE = 3'b101,
        CMD_LOCK_WRITE = 3'b110
    } nvlsa_cmd_type;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_BUSY = 1'b1
    } nvlsa_state_type;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
    } nvlsa_req_type;
endpackage : nvlsa_pkg

// >>> verilog/nvlsa_top.sv
// NVM lock, section decode and access control
`timescale 1ns/1ps
module nvlsa_top
    import nvlsa_pkg::*;
#(
    parameter int PROG_CYCLES = 8,
    parameter logic [7:0] SIG_MFR_ID = 8'h5A, // Arbitrary value
    parameter logic [7:0] SIG_DEV_ID1 = 8'h3C, // Arbitrary value
    parameter logic [7:0] SIG_DEV_ID2 = 8'h66, // Arbitrary value
    parameter logic [7:0] CAL_BYTE = 8'h7F
)
(
    input wire logic I_CORE_CLK,
    input wire logic I_RST_B,
    input wire logic I_SLEEP,
    input wire nvlsa_req_type I_CPU_REQ,
    input wire logic I_PRG_MODE,
    input wire logic I_PRG_CMD_WE,
    input wire nvlsa_cmd_type I_PRG_CMD,
    input wire nvlsa_req_type I_PRG_REQ,
    output logic O_CPU_STALL,
    output logic O_CPU_RD_VALID,
    output logic [7:0] O_CPU_RD_DATA,
    output logic O_CPU_WR_REJECT,
    output logic O_PRG_RD_VALID,
    output logic [7:0] O_PRG_RD_DATA,
    output logic O_PRG_REFUSED,
    output logic O_BUSY,
    output logic O_FLASH_EN,
    output logic [7:0] O_LOCK_BYTE,
    output logic O_EXT_RESET_DISABLE,
    output logic O_WATCHDOG_FORCED_ON,
    output logic O_SYSCLK_PIN_OUTPUT,
    output logic [2:0] O_BROWNOUT_LEVEL
);
    localparam int CNT_W = $clog2(PROG_CYCLES + 1);

    logic [15:0] code_mem [0:CODE_WORDS-1];
    logic [7:0] lock_q;
    logic [7:0] cfg_nv_q;
    logic [7:0] cfg_act_q;
    logic [7:0] lo_latch_q;
    nvlsa_cmd_type cmd_q;
    nvlsa_cmd_type op_q;
    nvlsa_state_type st_q;
    logic [CNT_W-1:0] cnt_q;
    logic [PADDR_MSB:WORD_IN_PAGE_ADDR_LSB] op_idx_q;
    logic [7:0] op_data_q;
    logic ld_pend_q;
    logic prg_mode_q;
    logic busy;
    logic done;
    logic flash_prog_blk;
    logic flash_vfy_blk;
    logic cfg_frozen;
    logic in_code;
    logic in_cfg;
    logic in_lock;
    logic in_ro;
    logic wr_ok;
    logic wr_start;
    logic prg_rd_ok;

    ////////////////////////////////////////////////////////////////////////
    // Section decode and read mux
    // Code word index
    function automatic logic [7:0] rd_byte(input logic [ADDR_W-1:0] a);
        logic [15:0] w;
        logic hi;
        w = {RSVD_BYTE, RSVD_BYTE};
        hi = a[BYTE_SEL_BIT];
        if (a[SEC_MSB:SEC_LSB] == SEC_CODE)
        begin
            w = code_mem[a[PADDR_MSB:WORD_IN_PAGE_ADDR_LSB]];
        end
        else if (a[SEC_MSB:SEG_LSB] == SEG_SIG)
        begin
            if ({a[SIG_PAGE_BIT], a[SIG_WORD_IN_PAGE_ADDR_MSB:WORD_IN_PAGE_ADDR_LSB]} == 5'h00)
                w = {SIG_DEV_ID1, SIG_MFR_ID};
            else if ({a[SIG_PAGE_BIT], a[SIG_WORD_IN_PAGE_ADDR_MSB:WORD_IN_PAGE_ADDR_LSB]} == 5'h01)
                w = {RSVD_BYTE, SIG_DEV_ID2};
        end
        else if (a[SEC_MSB:SEG_LSB] == SEG_CFG)
        begin
            if (a[WORD_IN_PAGE_ADDR_MSB:WORD_IN_PAGE_ADDR_LSB] == CFG_BYTE_WORD)
                w = {RSVD_BYTE, cfg_nv_q};
        end
        else if (a[SEC_MSB:SEG_LSB] == SEG_CAL)
        begin
            if (a[WORD_IN_PAGE_ADDR_MSB:WORD_IN_PAGE_ADDR_LSB] == 5'h00)
                w = {RSVD_BYTE, CAL_BYTE};
        end
        else if (a[SEC_MSB:SEG_LSB] == SEG_LOCK)
        begin
            if (a[WORD_IN_PAGE_ADDR_MSB:0] == LOCK_BYTE_OFS)
                w = {RSVD_BYTE, lock_q};
        end
        return hi ? w[15:8] : w[7:0];
    endfunction : rd_byte

    ////////////////////////////////////////////////////////////////////////
    // Protection decode
    assign busy = (st_q == ST_BUSY);
    assign done = busy && (cnt_q == '0);
    // Any programmed lock bit blocks flash writes
    assign flash_prog_blk = (lock_q[LB_TWO_BIT:LB_ONE_BIT] != LOCK_NONE);
    // Verification blocked when lock bit two programmed
    // Odd combination treated as mode 3
    assign flash_vfy_blk = !lock_q[LB_TWO_BIT];
    // Any programmed lock bit freezes config
    assign cfg_frozen = (lock_q[LB_TWO_BIT:LB_ONE_BIT] != LOCK_NONE);

    assign in_code = (I_PRG_REQ.addr[SEC_MSB:SEC_LSB] == SEC_CODE);
    assign in_cfg = (I_PRG_REQ.addr[SEC_MSB:SEG_LSB] == SEG_CFG);
    assign in_lock = (I_PRG_REQ.addr[SEC_MSB:SEG_LSB] == SEG_LOCK);
    assign in_ro = (I_PRG_REQ.addr[SEC_MSB:SEG_LSB] == SEG_SIG) || (I_PRG_REQ.addr[SEC_MSB:SEG_LSB] == SEG_CAL);

    // Only low byte of config word zero
    // Config erase is its own command
    always_comb
    begin
        wr_ok = 1'b0;
        if (in_code && I_PRG_REQ.addr[BYTE_SEL_BIT])
        begin
            wr_ok = (cmd_q == CMD_CHIP_ERASE) ||
                ((cmd_q == CMD_SECT_ERASE || cmd_q == CMD_CODE_WRITE) && !flash_prog_blk);
        end
        else if (in_cfg && !cfg_frozen)
        begin
            wr_ok = (cmd_q == CMD_CFG_ERASE) || ((cmd_q == CMD_CFG_WRITE) &&
                I_PRG_REQ.addr[WORD_IN_PAGE_ADDR_MSB:0] == {CFG_BYTE_WORD, 1'b0});
        end
        else if (in_lock && !in_ro)
        begin
            wr_ok = (cmd_q == CMD_LOCK_WRITE) && (I_PRG_REQ.addr[WORD_IN_PAGE_ADDR_MSB:0] == LOCK_BYTE_OFS);
        end
    end

    // Nothing starts or reads while busy
    assign wr_start = I_PRG_MODE && I_PRG_REQ.wr && !busy && wr_ok;
    assign prg_rd_ok = I_PRG_MODE && I_PRG_REQ.rd && !busy && !(in_code && flash_vfy_blk);

    ////////////////////////////////////////////////////////////////////////
    // Command register
    always_ff @(posedge I_CORE_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
            cmd_q <= CMD_NOP;
        else if (I_PRG_MODE && I_PRG_CMD_WE && !busy)
            cmd_q <= I_PRG_CMD;
    end

    ////////////////////////////////////////////////////////////////////////
    // Operation sequencer
    always_ff @(posedge I_CORE_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            st_q <= ST_IDLE;
            cnt_q <= '0;
            op_q <= CMD_NOP;
            op_idx_q <= '0;
            op_data_q <= 8'h00;
        end
        else
        begin
            unique case (st_q)
                ST_IDLE:
                begin
                    if (wr_start)
                    begin
                        st_q <= ST_BUSY;
                        cnt_q <= CNT_W'(PROG_CYCLES - 1);
                        op_q <= cmd_q;
                        op_idx_q <= I_PRG_REQ.addr[PADDR_MSB:WORD_IN_PAGE_ADDR_LSB];
                        op_data_q <= I_PRG_REQ.data;
                    end
                end
                ST_BUSY:
                begin
                    if (done)
                        st_q <= ST_IDLE;
                    else
                        cnt_q <= cnt_q - 1'b1;
                end
            endcase
        end
    end

    // Low byte staging for code words
    always_ff @(posedge I_CORE_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
            lo_latch_q <= 8'hFF;
        else if (I_PRG_MODE && I_PRG_REQ.wr && !busy && in_code && !I_PRG_REQ.addr[BYTE_SEL_BIT])
            lo_latch_q <= I_PRG_REQ.data;
    end

    // Code array, erase restores ones, write only clears bits
    always_ff @(posedge I_CORE_CLK)
    begin
        if (done && (op_q == CMD_CHIP_ERASE || op_q == CMD_SECT_ERASE))
        begin
            for (int i = 0; i < CODE_WORDS; i++)
                code_mem[i] <= WORD_ERASED;
        end
        else if (done && op_q == CMD_CODE_WRITE)
            code_mem[op_idx_q] <= code_mem[op_idx_q] & {op_data_q, lo_latch_q};
    end

    ////////////////////////////////////////////////////////////////////////
    // Lock and configuration storage
    always_ff @(posedge I_CORE_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
            lock_q <= LOCK_ERASED;
        // Lock bits set only by chip erase, in the same cycle as the code array
        else if (done && op_q == CMD_CHIP_ERASE)
            lock_q <= LOCK_ERASED;
        else if (done && op_q == CMD_LOCK_WRITE)
            lock_q <= lock_q & op_data_q;
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
            cfg_nv_q <= CFG_ERASED;
        else if (done && op_q == CMD_CFG_ERASE)
            cfg_nv_q <= CFG_ERASED;
        else if (done && op_q == CMD_CFG_WRITE)
            cfg_nv_q <= cfg_nv_q & op_data_q;
    end

    // Latch after reset release or mode exit
    always_ff @(posedge I_CORE_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            ld_pend_q <= 1'b1;
            prg_mode_q <= 1'b0;
            cfg_act_q <= CFG_ERASED;
        end
        else
        begin
            ld_pend_q <= 1'b0;
            prg_mode_q <= I_PRG_MODE;
            if (ld_pend_q || (prg_mode_q && !I_PRG_MODE))
                cfg_act_q <= cfg_nv_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Port answers
    always_ff @(posedge I_CORE_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            O_CPU_STALL <= 1'b0;
            O_CPU_RD_VALID <= 1'b0;
            O_CPU_RD_DATA <= 8'h00;
            O_CPU_WR_REJECT <= 1'b0;
            O_PRG_RD_VALID <= 1'b0;
            O_PRG_RD_DATA <= 8'h00;
            O_PRG_REFUSED <= 1'b0;
            O_BUSY <= 1'b0;
            O_FLASH_EN <= 1'b1;
        end
        else
        begin
            // One stall cycle per data read
            O_CPU_STALL <= I_CPU_REQ.rd;
            O_CPU_RD_VALID <= I_CPU_REQ.rd && !busy;
            if (I_CPU_REQ.rd && !busy)
                O_CPU_RD_DATA <= rd_byte(I_CPU_REQ.addr);
            O_CPU_WR_REJECT <= I_CPU_REQ.wr;
            O_PRG_RD_VALID <= prg_rd_ok;
            if (prg_rd_ok)
                O_PRG_RD_DATA <= rd_byte(I_PRG_REQ.addr);
            O_PRG_REFUSED <= I_PRG_MODE && ((I_PRG_REQ.rd && !prg_rd_ok) ||
                (I_PRG_REQ.wr && !wr_ok && !(in_code && !I_PRG_REQ.addr[BYTE_SEL_BIT] && !busy)) ||
                (I_PRG_REQ.wr && busy));
            O_BUSY <= wr_start || (busy && !done);
            // Flash off in sleep when idle
            O_FLASH_EN <= !(I_SLEEP && !busy && !wr_start);
        end
    end

    assign O_LOCK_BYTE = lock_q;
    assign O_EXT_RESET_DISABLE = cfg_act_q[CFG_RST_DIS_BIT];
    assign O_WATCHDOG_FORCED_ON = cfg_act_q[CFG_WDT_BIT];
    assign O_SYSCLK_PIN_OUTPUT = cfg_act_q[CFG_SYSCLK_PIN_OUTPUT_BIT];
    assign O_BROWNOUT_LEVEL = cfg_act_q[CFG_BOD_MSB:CFG_BOD_LSB];

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_B);

    sequence s_cpu_read;
        I_CPU_REQ.rd && !busy;
    endsequence

    a_read_one_stall: assert property (s_cpu_read |=> O_CPU_STALL && O_CPU_RD_VALID)
        else $error("read not answered with one stall");
    a_flash_sleep_off: assert property (I_SLEEP && !busy && !wr_start |=> !O_FLASH_EN)
        else $error("flash left on in idle sleep");
    a_cpu_write_void: assert property (I_CPU_REQ.wr && !I_PRG_MODE |=> O_CPU_WR_REJECT && $stable(lock_q))
        else $error("application write took effect");
    a_ro_write_refused: assert property (I_PRG_MODE && I_PRG_REQ.wr && in_ro |=> O_PRG_REFUSED && (!O_BUSY || $past(busy)))
        else $error("read-only section accepted a write");
    a_lock_no_set: assert property (!(done && op_q == CMD_CHIP_ERASE) |=> (lock_q & ~$past(lock_q)) == 8'h00)
        else $error("lock bit returned high without erase");
    a_cfg_frozen_refused: assert property (cfg_frozen && I_PRG_MODE && I_PRG_REQ.wr && in_cfg && !busy
        |=> O_PRG_REFUSED && !O_BUSY)
        else $error("config changed while locked");
    a_verify_blocked: assert property (flash_vfy_blk && I_PRG_MODE && I_PRG_REQ.rd && in_code
        |=> !O_PRG_RD_VALID && O_PRG_REFUSED)
        else $error("flash verify read under lock");
    a_chip_keeps_cfg: assert property (done && op_q == CMD_CHIP_ERASE |=> $stable(cfg_nv_q))
        else $error("chip erase altered config");
    a_cmd_busy_hold: assert property (busy ##0 I_PRG_CMD_WE |=> $stable(cmd_q))
        else $error("command taken while busy");
    a_busy_no_read: assert property (busy && I_CPU_REQ.rd |=> !O_CPU_RD_VALID ##0 O_CPU_STALL)
        else $error("read served while busy");
    a_cfg_latch_hold: assert property (prg_mode_q && I_PRG_MODE && !ld_pend_q |=> $stable(cfg_act_q))
        else $error("config applied inside programming mode");
endmodule : nvlsa_top

// >>> testbench/nvlsa_prog_model.sv
// Programmer model driving the programming port of the block
`timescale 1ns/1ps
module nvlsa_prog_model
    import nvlsa_pkg::*;
(
    input wire logic i_clk,
    output logic o_mode,
    output logic o_cmd_we,
    output nvlsa_cmd_type o_cmd,
    output nvlsa_req_type o_req
);
    initial
    begin
        o_mode = 1'b0;
        o_cmd_we = 1'b0;
        o_cmd = CMD_NOP;
        o_req = '0;
    end
    task set_mode(input logic m);
        @(posedge i_clk);
        o_mode <= m;
    endtask : set_mode
    task cmd(input nvlsa_cmd_type c);
        @(posedge i_clk);
        o_cmd_we <= 1'b1;
        o_cmd <= c;
        @(posedge i_clk);
        o_cmd_we <= 1'b0;
    endtask : cmd
    // Released address and data lines show inverted values, strobes drop to zero
    task xfer(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_req <= '{rd: !w, wr: w, addr: a, data: d};
        @(posedge i_clk);
        o_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, data: ~d};
    endtask : xfer
endmodule : nvlsa_prog_model

// >>> testbench/nvlsa_top_bench.sv
// Self-checking bench for the NVM lock and section access block
`timescale 1ns/1ps
module nvlsa_top_bench;
    import nvlsa_pkg::*;
    localparam logic [7:0] SA = 8'h5A;
    localparam logic [7:0] SB = 8'h3C;
    localparam logic [7:0] SC = 8'h66;
    localparam logic [7:0] CB = 8'h7F;
    localparam int PC = 8;
    logic clk, rst_b, sleep, mode, cmd_we;
    nvlsa_cmd_type cmd;
    nvlsa_req_type cpu_req, prg_req;
    logic cstall, cvld, crej, pvld, pref, busy, fen, rdis, wdt, sysclk_pin_output;
    logic [7:0] cdat, pdat, lock, lo, hi, cv;
    logic [2:0] bod;
    logic [15:0] a;
    logic [9:0] cq[$];
    logic [9:0] pq[$];
    int miscompares, compares, cyc, nb;
    logic [15:0] ta[8] = '{16'h3F00, 16'h3F40, 16'h3F41, 16'h3F80, 16'h3FC0, 16'h3FC1, 16'h3FC2, 16'h3FE0};
    logic [7:0] te[8] = '{8'hFF, 8'hFF, 8'hFF, CB, SA, SB, SC, 8'hFF};

    nvlsa_top #(.SIG_MFR_ID(SA), .SIG_DEV_ID1(SB), .SIG_DEV_ID2(SC), .CAL_BYTE(CB)) dut (
        .I_CORE_CLK(clk), .I_RST_B(rst_b), .I_SLEEP(sleep), .I_CPU_REQ(cpu_req), .I_PRG_MODE(mode),
        .I_PRG_CMD_WE(cmd_we), .I_PRG_CMD(cmd), .I_PRG_REQ(prg_req), .O_CPU_STALL(cstall),
        .O_CPU_RD_VALID(cvld), .O_CPU_RD_DATA(cdat), .O_CPU_WR_REJECT(crej), .O_PRG_RD_VALID(pvld),
        .O_PRG_RD_DATA(pdat), .O_PRG_REFUSED(pref), .O_BUSY(busy), .O_FLASH_EN(fen), .O_LOCK_BYTE(lock),
        .O_EXT_RESET_DISABLE(rdis), .O_WATCHDOG_FORCED_ON(wdt), .O_SYSCLK_PIN_OUTPUT(sysclk_pin_output),
        .O_BROWNOUT_LEVEL(bod));
    nvlsa_prog_model prg (.i_clk(clk), .o_mode(mode), .o_cmd_we(cmd_we), .o_cmd(cmd), .o_req(prg_req));

    ////////////////////////////////////////////////////////////////////////
    task final_report();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report
    task chk(input logic [9:0] got, input logic [9:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task cfgchk(input logic [7:0] v);
        chk({4'h0, bod, sysclk_pin_output, wdt, rdis}, {4'h0, v[6:4], v[2:0]});
    endtask : cfgchk
    task crd(input logic [15:0] ad, input logic [7:0] e);
        cq.push_back({2'b10, e});
        @(posedge clk);
        cpu_req <= '{rd: 1'b1, wr: 1'b0, addr: ad, data: 8'($urandom)};
        sleep <= 1'($urandom);
        @(posedge clk);
        cpu_req.rd <= 1'b0;
    endtask : crd
    // Read while busy: stall only, no data
    task cbusy(input logic [15:0] ad);
        @(posedge clk);
        cpu_req <= '{rd: 1'b1, wr: 1'b0, addr: ad, data: 8'h5A};
        @(posedge clk);
        cpu_req.rd <= 1'b0;
        @(negedge clk);
        chk({8'h00, cstall, cvld}, 10'h002);
    endtask : cbusy
    task cwr(input logic [15:0] ad, input logic [7:0] d);
        cq.push_back(10'h100);
        @(posedge clk);
        cpu_req <= '{rd: 1'b0, wr: 1'b1, addr: ad, data: d};
        @(posedge clk);
        cpu_req.wr <= 1'b0;
    endtask : cwr
    task prd(input logic [15:0] ad, input logic [7:0] e, input logic r);
        pq.push_back(r ? 10'h100 : {2'b00, e});
        prg.xfer(1'b0, ad, 8'h00);
    endtask : prd
    task pwr(input logic [15:0] ad, input logic [7:0] d, input logic r);
        if (r)
            pq.push_back(10'h100);
        prg.xfer(1'b1, ad, d);
    endtask : pwr
    task idle();
        nb = 0;
        repeat (40)
        begin
            @(negedge clk);
            if (busy === 1'b0)
                break;
            nb++;
        end
    endtask : idle

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk)
    begin
        cyc++;
        if (cvld === 1'b1 || crej === 1'b1)
            chk({cstall, crej, crej ? 8'h00 : cdat}, cq.size() ? cq.pop_front() : 'x);
        if (pvld === 1'b1 || pref === 1'b1)
            chk({1'b0, pref, pref ? 8'h00 : pdat}, pq.size() ? pq.pop_front() : 'x);
        if (cyc == 5000)
        begin
            miscompares++;
            final_report();
        end
    end
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial
    begin
        rst_b = 1'b0;
        sleep = 1'b0;
        cpu_req = '0;
        miscompares = 0;
        compares = 0;
        cyc = 0;
        void'($urandom(9));
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        chk({2'b00, lock}, 10'h0FF);
        cfgchk(8'hFF);
        for (int i = 0; i < 8; i++)
            crd(ta[i], te[i]);
        cwr(16'h3F00, 8'h00);
        crd(16'h3F00, 8'hFF);
        prg.set_mode(1'b1);
        prg.cmd(CMD_CHIP_ERASE);
        pwr(16'h4001, 8'h00, 1'b0);
        sleep <= 1'b1;
        @(negedge clk);
        chk({9'h0, fen}, 10'h001);
        cbusy(16'h3FC0);
        idle();
        repeat (2) @(negedge clk);
        chk({9'h0, fen}, 10'h000);
        a = {4'h4, 12'($urandom) & 12'hFF8};
        lo = 8'($urandom);
        hi = 8'($urandom);
        prg.cmd(CMD_CODE_WRITE);
        pwr(a, lo, 1'b0);
        pwr(a | 16'h0001, hi, 1'b0);
        prd(a, 8'h00, 1'b1);
        prg.cmd(CMD_CFG_WRITE);
        idle();
        pwr(a | 16'h0004, lo, 1'b0);
        pwr(a | 16'h0005, hi, 1'b0);
        idle();
        prd(a, lo, 1'b0);
        prd(a | 16'h0001, hi, 1'b0);
        crd(a | 16'h0004, lo);
        crd(a | 16'h0005, hi);
        pwr(16'h3FC0, 8'h00, 1'b1);
        cv = 8'($urandom);
        prg.cmd(CMD_CFG_WRITE);
        pwr(16'h3F41, 8'h00, 1'b1);
        pwr(16'h3F40, cv, 1'b0);
        idle();
        cfgchk(8'hFF);
        prd(16'h3F40, cv, 1'b0);
        prg.set_mode(1'b0);
        repeat (3) @(negedge clk);
        cfgchk(cv);
        prg.set_mode(1'b1);
        prg.cmd(CMD_LOCK_WRITE);
        pwr(16'h3F00, 8'hFE, 1'b0);
        idle();
        chk(10'(nb), 10'(PC));
        prd(16'h3F00, 8'hFE, 1'b0);
        prg.cmd(CMD_CODE_WRITE);
        pwr(a | 16'h0001, 8'h00, 1'b1);
        prd(a, lo, 1'b0);
        prg.cmd(CMD_CFG_ERASE);
        pwr(16'h3F40, 8'h00, 1'b1);
        prg.cmd(CMD_LOCK_WRITE);
        pwr(16'h3F00, 8'hFC, 1'b0);
        idle();
        prd(a, 8'h00, 1'b1);
        prd(16'h3FC0, SA, 1'b0);
        prg.cmd(CMD_CHIP_ERASE);
        pwr(16'h4001, 8'h00, 1'b0);
        idle();
        chk({2'b00, lock}, 10'h0FF);
        prd(a, 8'hFF, 1'b0);
        prd(16'h3F40, cv, 1'b0);
        prg.cmd(CMD_CFG_ERASE);
        pwr(16'h3F40, 8'h00, 1'b0);
        idle();
        prd(16'h3F40, 8'hFF, 1'b0);
        prg.cmd(CMD_LOCK_WRITE);
        pwr(16'h3F00, 8'hFD, 1'b0);
        idle();
        pwr(16'h3F00, 8'hFF, 1'b0);
        idle();
        prd(16'h3F00, 8'hFD, 1'b0);
        prd(a, 8'h00, 1'b1);
        prg.set_mode(1'b0);
        repeat (3) @(negedge clk);
        cfgchk(8'hFF);
        repeat (4) @(negedge clk);
        if (cq.size() + pq.size() != 0)
            miscompares++;
        final_report();
    end
endmodule : nvlsa_top_bench
